// ---- verilog/caf_card.sv ----
// Purpose: Card end, checks command APDUs and frames response APDUs
// Assumes: Card contents arrive as static user-side inputs
// Notes: Response bytes pass an 8-word FIFO before the link
`timescale 1ns/1ps
module caf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and occupancy update
  always_comb begin
    wp_nxt = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // Storage and pointers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (push) begin
        mem[wp_r] <= in_data;
      end
    end
  end
endmodule : caf_fifo

// Behaviour
// - Host sends class byte 0x90 always
// - Class: private pattern, no messaging, no channel
// - Host never sends odd, 6x, 9x instruction
// - Host sends both parameter bytes as zero
// - Host omits Lc when no data
// - Host sends Le zero; any response length
// - Length fields are single bytes only
// - Response: optional body then SW1, SW2
// - Status words supplementary; detail in data
// - Only unit number zero has defined payload
// - Unit starts with number and length bytes
// - Unit zero: instruction, return code, data
// - Initial settings command: 90 30 00 00 00
// - Initial settings fields in fixed order
// - Count N, N identifiers, then trailer
// - Individual ID; group held signals acquire instruction
// - Card type 00 prepaid, 01 standard
module caf_card #(
  parameter int MAX_MGMT = 8,
  parameter int FIFO_DEPTH = 8,
  parameter logic [15:0] ACQUIRE_ID_INSTR = 16'h0001
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  caf_link_if.card_end link,
  input wire logic [15:0] access_system_identifier,
  input wire logic [47:0] card_identity_value,
  input wire logic prepaid,
  input wire logic [7:0] partition_len,
  input wire logic [255:0] descramble_key,
  input wire logic [63:0] cbc_init,
  input wire logic [7:0] mgmt_count,
  input wire logic [16*MAX_MGMT-1:0] broadcast_management_code,
  input wire logic group_held,
  input wire logic [15:0] card_instr,
  input wire logic [15:0] return_code,
  input wire logic [15:0] status_ok,
  output logic [7:0] cmd_ins_r,
  output logic [7:0] cmd_data_r,
  output logic cmd_data_valid_r,
  output logic cmd_done_r
);
  typedef enum {C_CLA, C_INS, C_P1, C_P2, C_LEN, C_DATA, C_LE, C_RESP} caf_cstate_t;
  caf_cstate_t state_r, state_nxt;
  caf_pkg::caf_rkind_t kind_r, kind_nxt;
  logic rdy_r, rdy_nxt, bcla_r, bcla_nxt, bins_r, bins_nxt, bpar_r, bpar_nxt;
  logic [7:0] ins_nxt, dat_nxt, cnt_r, cnt_nxt, idx_r, idx_nxt, n_r, n_nxt;
  logic dv_nxt, done_nxt, got, f_ready, f_push, is_last;
  logic [7:0] body_len, total_len, unit_len, rbyte, k;
  logic [15:0] sw, instr;
  logic [8:0] f_out;

  assign link.cmd_ready = rdy_r;
  assign got = rdy_r && link.cmd_valid;

  // Response length from kind and identifier count
  always_comb begin
    unit_len = (kind_r == caf_pkg::CAF_RK_INIT) ? caf_pkg::CAF_INIT_FIXED_LEN + {n_r[6:0], 1'b0}
      : caf_pkg::CAF_PLAIN_UNIT_LEN;
    body_len = (kind_r == caf_pkg::CAF_RK_ERR) ? 8'h00 : caf_pkg::CAF_UNIT_HDR_LEN + unit_len;
    total_len = body_len + caf_pkg::CAF_TRAILER_LEN;
    is_last = (idx_r == total_len - 8'h01);
  end

  // Status and card instruction selection
  always_comb begin
    if (kind_r == caf_pkg::CAF_RK_ERR) begin
      sw = bcla_r ? caf_pkg::CAF_SW_BAD_CLA : (bins_r ? caf_pkg::CAF_SW_BAD_INS : caf_pkg::CAF_SW_BAD_PAR);
    end else begin
      sw = status_ok;
    end
    instr = (kind_r == caf_pkg::CAF_RK_INIT && group_held) ? ACQUIRE_ID_INSTR : card_instr;
  end

  // Byte at the current response index, most significant first
  always_comb begin
    k = idx_r - caf_pkg::CAF_IX_MGMT;
    rbyte = 8'h00;
    if (idx_r == body_len) begin
      rbyte = sw[15:8];
    end else if (idx_r > body_len) begin
      rbyte = sw[7:0];
    end else if (idx_r == 8'h00) begin
      rbyte = caf_pkg::CAF_UNIT_NUM0;
    end else if (idx_r == 8'h01) begin
      rbyte = unit_len;
    end else if (idx_r < caf_pkg::CAF_IX_RCODE) begin
      rbyte = (idx_r == caf_pkg::CAF_IX_INSTR) ? instr[15:8] : instr[7:0];
    end else if (idx_r < caf_pkg::CAF_IX_SYSID) begin
      rbyte = (idx_r == caf_pkg::CAF_IX_RCODE) ? return_code[15:8] : return_code[7:0];
    end else if (idx_r < caf_pkg::CAF_IX_CARDID) begin
      rbyte = (idx_r == caf_pkg::CAF_IX_SYSID) ? access_system_identifier[15:8]
        : access_system_identifier[7:0];
    end else if (idx_r < caf_pkg::CAF_IX_TYPE) begin
      rbyte = card_identity_value[8*(caf_pkg::CAF_CARDID_BYTES - 1 - int'(idx_r - caf_pkg::CAF_IX_CARDID)) +: 8];
    end else if (idx_r == caf_pkg::CAF_IX_TYPE) begin
      rbyte = prepaid ? caf_pkg::CAF_CARD_PREPAID : caf_pkg::CAF_CARD_STANDARD;
    end else if (idx_r == caf_pkg::CAF_IX_PART) begin
      rbyte = partition_len;
    end else if (idx_r < caf_pkg::CAF_IX_CBC) begin
      rbyte = descramble_key[8*(caf_pkg::CAF_KEY_BYTES - 1 - int'(idx_r - caf_pkg::CAF_IX_KEY)) +: 8];
    end else if (idx_r < caf_pkg::CAF_IX_COUNT) begin
      rbyte = cbc_init[8*(caf_pkg::CAF_CBC_BYTES - 1 - int'(idx_r - caf_pkg::CAF_IX_CBC)) +: 8];
    end else if (idx_r == caf_pkg::CAF_IX_COUNT) begin
      rbyte = n_r;
    end else begin
      rbyte = broadcast_management_code[16*int'(k[7:1]) + (k[0] ? 0 : 8) +: 8];
    end
  end

  assign f_push = (state_r == C_RESP);

  // Command parser and response sequencer
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    bcla_nxt = bcla_r;
    bins_nxt = bins_r;
    bpar_nxt = bpar_r;
    ins_nxt = cmd_ins_r;
    dat_nxt = cmd_data_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    n_nxt = n_r;
    dv_nxt = 1'b0;
    done_nxt = 1'b0;
    case (state_r)
      C_CLA: if (got) begin
        bcla_nxt = (link.cmd_byte != caf_pkg::CAF_CLA_VALUE);
        state_nxt = C_INS;
      end
      C_INS: if (got) begin
        ins_nxt = link.cmd_byte;
        bins_nxt = link.cmd_byte[0] || (link.cmd_byte[7:4] == caf_pkg::CAF_INS_BAD_HI_A) ||
          (link.cmd_byte[7:4] == caf_pkg::CAF_INS_BAD_HI_B);
        state_nxt = C_P1;
      end
      C_P1: if (got) begin
        bpar_nxt = (link.cmd_byte != caf_pkg::CAF_PARAM_ZERO);
        state_nxt = C_P2;
      end
      C_P2: if (got) begin
        bpar_nxt = bpar_r || (link.cmd_byte != caf_pkg::CAF_PARAM_ZERO);
        state_nxt = C_LEN;
      end
      C_LEN: if (got) begin
        if (link.cmd_byte == caf_pkg::CAF_LE_ZERO || link.cmd_last) begin
          state_nxt = C_RESP;
        end else begin
          cnt_nxt = link.cmd_byte;
          state_nxt = C_DATA;
        end
      end
      C_DATA: if (got) begin
        dat_nxt = link.cmd_byte;
        dv_nxt = 1'b1;
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          state_nxt = C_LE;
        end
      end
      C_LE: if (got) begin
        state_nxt = C_RESP;
      end
      C_RESP: if (f_ready) begin
        idx_nxt = idx_r + 8'h01;
        if (is_last) begin
          idx_nxt = 8'h00;
          state_nxt = C_CLA;
        end
      end
      default: state_nxt = C_CLA;
    endcase
    if (state_nxt == C_RESP && state_r != C_RESP) begin
      done_nxt = 1'b1;
      idx_nxt = 8'h00;
      n_nxt = (mgmt_count > 8'(MAX_MGMT)) ? 8'(MAX_MGMT) : mgmt_count;
      if (bcla_nxt || bins_nxt || bpar_nxt) begin
        kind_nxt = caf_pkg::CAF_RK_ERR;
      end else if (ins_nxt == caf_pkg::CAF_INS_INIT) begin
        kind_nxt = caf_pkg::CAF_RK_INIT;
      end else begin
        kind_nxt = caf_pkg::CAF_RK_PLAIN;
      end
    end
    rdy_nxt = (state_nxt != C_RESP);
  end

  // State registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= C_CLA;
      kind_r <= caf_pkg::CAF_RK_PLAIN;
      rdy_r <= 1'b0;
      bcla_r <= 1'b0;
      bins_r <= 1'b0;
      bpar_r <= 1'b0;
      cmd_ins_r <= 8'h00;
      cmd_data_r <= 8'h00;
      cmd_data_valid_r <= 1'b0;
      cmd_done_r <= 1'b0;
      cnt_r <= 8'h00;
      idx_r <= 8'h00;
      n_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      rdy_r <= rdy_nxt;
      bcla_r <= bcla_nxt;
      bins_r <= bins_nxt;
      bpar_r <= bpar_nxt;
      cmd_ins_r <= ins_nxt;
      cmd_data_r <= dat_nxt;
      cmd_data_valid_r <= dv_nxt;
      cmd_done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      n_r <= n_nxt;
    end
  end

  // Response bytes with end flag toward the link
  caf_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rsp_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_data({is_last, rbyte}),
    .in_valid(f_push),
    .in_ready(f_ready),
    .out_data(f_out),
    .out_valid(link.rsp_valid),
    .out_ready(link.rsp_ready)
  );

  assign link.rsp_byte = f_out[7:0];
  assign link.rsp_last = f_out[8];
endmodule : caf_card

// ---- verilog/caf_pkg.sv ----
// Purpose: Shared constants for card command and response APDU framing
// Assumes: One byte per link beat, most significant byte first
// Notes: Response byte indices count from the first data byte of the response
package caf_pkg;
  // Command header values
  localparam logic [7:0] CAF_CLA_VALUE = 8'h90;
  localparam logic [3:0] CAF_CLA_PRIVATE = 4'h9;
  localparam logic [7:0] CAF_PARAM_ZERO = 8'h00;
  localparam logic [7:0] CAF_LE_ZERO = 8'h00;
  localparam logic [7:0] CAF_INS_INIT = 8'h30;
  localparam logic [3:0] CAF_INS_BAD_HI_A = 4'h6;
  localparam logic [3:0] CAF_INS_BAD_HI_B = 4'h9;
  // Card type codes
  localparam logic [7:0] CAF_CARD_PREPAID = 8'h00;
  localparam logic [7:0] CAF_CARD_STANDARD = 8'h01;
  // Protocol unit
  localparam logic [7:0] CAF_UNIT_NUM0 = 8'h00;
  localparam logic [7:0] CAF_UNIT_HDR_LEN = 8'h02;
  localparam logic [7:0] CAF_PLAIN_UNIT_LEN = 8'h04;
  localparam logic [7:0] CAF_INIT_FIXED_LEN = 8'h37;
  // Byte indices in the initial settings response
  localparam logic [7:0] CAF_IX_INSTR = 8'h02;
  localparam logic [7:0] CAF_IX_RCODE = 8'h04;
  localparam logic [7:0] CAF_IX_SYSID = 8'h06;
  localparam logic [7:0] CAF_IX_CARDID = 8'h08;
  localparam logic [7:0] CAF_IX_TYPE = 8'h0e;
  localparam logic [7:0] CAF_IX_PART = 8'h0f;
  localparam logic [7:0] CAF_IX_KEY = 8'h10;
  localparam logic [7:0] CAF_IX_CBC = 8'h30;
  localparam logic [7:0] CAF_IX_COUNT = 8'h38;
  localparam logic [7:0] CAF_IX_MGMT = 8'h39;
  // Field sizes in bytes
  localparam int CAF_CARDID_BYTES = 6;
  localparam int CAF_KEY_BYTES = 32;
  localparam int CAF_CBC_BYTES = 8;
  localparam logic [7:0] CAF_TRAILER_LEN = 8'h02;
  // Status words for refused commands
  localparam logic [15:0] CAF_SW_BAD_CLA = 16'h6e00;
  localparam logic [15:0] CAF_SW_BAD_INS = 16'h6d00;
  localparam logic [15:0] CAF_SW_BAD_PAR = 16'h6b00;
  // Response kinds
  typedef enum logic [1:0] {CAF_RK_INIT, CAF_RK_PLAIN, CAF_RK_ERR} caf_rkind_t;
endpackage : caf_pkg

// ---- verilog/caf_link_if.sv ----
// Purpose: Byte link between the receiver host and the card
// Assumes: Both ends on sys_clk; valid and ready handshake per byte
// Notes: last marks the final byte of a command or response APDU
`timescale 1ns/1ps
interface caf_link_if;
  logic [7:0] cmd_byte;
  logic cmd_valid;
  logic cmd_ready;
  logic cmd_last;
  logic [7:0] rsp_byte;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_last;
  // Receiver host end
  modport receiver_host (output cmd_byte, output cmd_valid, input cmd_ready, output cmd_last,
    input rsp_byte, input rsp_valid, output rsp_ready, input rsp_last);
  // Card end
  modport card_end (input cmd_byte, input cmd_valid, output cmd_ready, input cmd_last,
    output rsp_byte, output rsp_valid, input rsp_ready, output rsp_last);
endinterface : caf_link_if

// ---- verilog/caf_host.sv ----
// Purpose: Receiver host end, builds command APDUs and collects responses
// Assumes: User supplies command data bytes on a valid and ready stream
// Notes: Holding register on the response side halves peak throughput
`timescale 1ns/1ps
module caf_host (
  input wire logic sys_clk,
  input wire logic reset_n,
  caf_link_if.receiver_host link,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_ins,
  input wire logic [7:0] cmd_lc,
  input wire logic [7:0] data_in,
  input wire logic data_in_valid,
  output logic data_in_ready_r,
  output logic busy_r,
  output logic reject_r,
  output logic [7:0] resp_data_r,
  output logic resp_valid_r,
  output logic resp_last_r,
  input wire logic resp_ready,
  output logic [15:0] status_word_r,
  output logic done_r
);
  typedef enum {H_IDLE, H_CLA, H_INS, H_P1, H_P2, H_LC, H_FETCH, H_DATA, H_LE, H_WAIT} caf_hstate_t;
  caf_hstate_t state_r, state_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic valid_r, valid_nxt, last_r, last_nxt, fetch_r, fetch_nxt;
  logic [7:0] ins_r, ins_nxt, cnt_r, cnt_nxt;
  logic rej_nxt, rrdy_r, rrdy_nxt, hv_nxt, hl_nxt, done_nxt;
  logic [7:0] hd_nxt, prev_r, prev_nxt;
  logic [15:0] sw_nxt;
  logic sent, ins_bad, took, busy_nxt;

  assign link.cmd_byte = byte_r;
  assign link.cmd_valid = valid_r;
  assign link.cmd_last = last_r;
  assign link.rsp_ready = rrdy_r;
  assign data_in_ready_r = fetch_r;
  assign busy_nxt = (state_nxt != H_IDLE);
  assign sent = valid_r && link.cmd_ready;
  assign took = rrdy_r && link.rsp_valid;
  // Odd codes and the two reserved upper nibbles are never sent
  assign ins_bad = cmd_ins[0] || (cmd_ins[7:4] == caf_pkg::CAF_INS_BAD_HI_A) ||
    (cmd_ins[7:4] == caf_pkg::CAF_INS_BAD_HI_B);

  // Command sequencer, one header or body byte per state
  always_comb begin
    state_nxt = state_r;
    byte_nxt = byte_r;
    valid_nxt = valid_r;
    last_nxt = last_r;
    fetch_nxt = 1'b0;
    ins_nxt = ins_r;
    cnt_nxt = cnt_r;
    rej_nxt = 1'b0;
    case (state_r)
      H_IDLE: begin
        if (cmd_start && ins_bad) begin
          rej_nxt = 1'b1;
        end else if (cmd_start) begin
          ins_nxt = cmd_ins;
          cnt_nxt = cmd_lc;
          byte_nxt = caf_pkg::CAF_CLA_VALUE;
          valid_nxt = 1'b1;
          state_nxt = H_CLA;
        end
      end
      H_CLA: if (sent) begin
        byte_nxt = ins_r;
        state_nxt = H_INS;
      end
      H_INS: if (sent) begin
        byte_nxt = caf_pkg::CAF_PARAM_ZERO;
        state_nxt = H_P1;
      end
      H_P1: if (sent) begin
        byte_nxt = caf_pkg::CAF_PARAM_ZERO;
        state_nxt = H_P2;
      end
      H_P2: if (sent) begin
        if (cnt_r == 8'h00) begin
          byte_nxt = caf_pkg::CAF_LE_ZERO;
          last_nxt = 1'b1;
          state_nxt = H_LE;
        end else begin
          byte_nxt = cnt_r;
          state_nxt = H_LC;
        end
      end
      H_LC: if (sent) begin
        valid_nxt = 1'b0;
        fetch_nxt = 1'b1;
        state_nxt = H_FETCH;
      end
      H_FETCH: begin
        fetch_nxt = !(data_in_valid && fetch_r);
        if (data_in_valid && fetch_r) begin
          byte_nxt = data_in;
          valid_nxt = 1'b1;
          cnt_nxt = cnt_r - 8'h01;
          state_nxt = H_DATA;
        end
      end
      H_DATA: if (sent) begin
        if (cnt_r == 8'h00) begin
          byte_nxt = caf_pkg::CAF_LE_ZERO;
          last_nxt = 1'b1;
          state_nxt = H_LE;
        end else begin
          valid_nxt = 1'b0;
          fetch_nxt = 1'b1;
          state_nxt = H_FETCH;
        end
      end
      H_LE: if (sent) begin
        valid_nxt = 1'b0;
        last_nxt = 1'b0;
        state_nxt = H_WAIT;
      end
      H_WAIT: if (took && link.rsp_last) begin
        state_nxt = H_IDLE;
      end
      default: state_nxt = H_IDLE;
    endcase
  end

  // Response collection, trailer is the last two bytes
  always_comb begin
    hv_nxt = resp_valid_r && !resp_ready;
    hd_nxt = resp_data_r;
    hl_nxt = resp_last_r;
    prev_nxt = prev_r;
    sw_nxt = status_word_r;
    done_nxt = 1'b0;
    if (took) begin
      hv_nxt = 1'b1;
      hd_nxt = link.rsp_byte;
      hl_nxt = link.rsp_last;
      prev_nxt = link.rsp_byte;
      if (link.rsp_last) begin
        sw_nxt = {prev_r, link.rsp_byte};
        done_nxt = 1'b1;
      end
    end
    rrdy_nxt = !hv_nxt;
  end

  // State registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= H_IDLE;
      byte_r <= 8'h00;
      valid_r <= 1'b0;
      last_r <= 1'b0;
      fetch_r <= 1'b0;
      ins_r <= 8'h00;
      cnt_r <= 8'h00;
      reject_r <= 1'b0;
      rrdy_r <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_data_r <= 8'h00;
      resp_last_r <= 1'b0;
      prev_r <= 8'h00;
      status_word_r <= 16'h0000;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      byte_r <= byte_nxt;
      valid_r <= valid_nxt;
      last_r <= last_nxt;
      fetch_r <= fetch_nxt;
      ins_r <= ins_nxt;
      cnt_r <= cnt_nxt;
      reject_r <= rej_nxt;
      rrdy_r <= rrdy_nxt;
      resp_valid_r <= hv_nxt;
      resp_data_r <= hd_nxt;
      resp_last_r <= hl_nxt;
      prev_r <= prev_nxt;
      status_word_r <= sw_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end
endmodule : caf_host

// ---- tb/caf_link_chk.sv ----
// Purpose: Watches the command and response byte link between host and card
// Assumes: Only well-formed host commands travel this link
// Notes: Byte positions count accepted bytes since the last byte marked last
`timescale 1ns/1ps
module caf_link_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_last,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_last
);
  logic [7:0] cpos_r, cpos_nxt, rpos_r, rpos_nxt, rlen_r, rlen_nxt;
  // Positions within each APDU and the captured unit length
  always_comb begin
    cpos_nxt = cpos_r;
    rpos_nxt = rpos_r;
    rlen_nxt = rlen_r;
    if (cmd_valid && cmd_ready) cpos_nxt = cmd_last ? 8'h00 : cpos_r + 8'h01;
    if (rsp_valid && rsp_ready) rpos_nxt = rsp_last ? 8'h00 : rpos_r + 8'h01;
    if (rsp_valid && rsp_ready && rpos_r == 8'h01) rlen_nxt = rsp_byte;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpos_r <= 8'h00;
      rpos_r <= 8'h00;
      rlen_r <= 8'h00;
    end else begin
      cpos_r <= cpos_nxt;
      rpos_r <= rpos_nxt;
      rlen_r <= rlen_nxt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_cla;
    cmd_valid && cpos_r == 8'h00 |-> cmd_byte == 8'h90 && cmd_byte[3:0] == 4'h0;
  endproperty
  a_cla: assert property (p_cla) else $error("class byte wrong");
  property p_ins;
    cmd_valid && cpos_r == 8'h01 |-> !cmd_byte[0] && cmd_byte[7:4] != 4'h6 && cmd_byte[7:4] != 4'h9;
  endproperty
  a_ins: assert property (p_ins) else $error("invalid instruction sent");
  property p_par;
    cmd_valid && (cpos_r == 8'h02 || cpos_r == 8'h03) |-> cmd_byte == 8'h00;
  endproperty
  a_par: assert property (p_par) else $error("parameter byte not zero");
  property p_lc;
    cmd_valid && cpos_r == 8'h04 && !cmd_last |-> cmd_byte != 8'h00;
  endproperty
  a_lc: assert property (p_lc) else $error("zero length byte sent");
  property p_le;
    cmd_valid && cmd_last |-> cmd_byte == 8'h00 && cpos_r >= 8'h04;
  endproperty
  a_le: assert property (p_le) else $error("closing length byte wrong");
  property p_unit0;
    rsp_valid && rpos_r == 8'h00 |-> rsp_byte == 8'h00 && !rsp_last;
  endproperty
  a_unit0: assert property (p_unit0) else $error("unit number not zero");
  property p_trl;
    rsp_valid && rsp_last |-> rpos_r == rlen_r + 8'h03;
  endproperty
  a_trl: assert property (p_trl) else $error("trailer not after unit");
  property p_rhold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte) && $stable(rsp_last);
  endproperty
  a_rhold: assert property (p_rhold) else $error("response byte dropped");
  property p_turn;
    cmd_valid && cmd_ready && cmd_last |-> ##[1:4] rsp_valid;
  endproperty
  a_turn: assert property (p_turn) else $error("response late");
endmodule : caf_link_chk

// ---- tb/card_apdu_framing_tb.sv ----
// Purpose: Host and card joined on one link, driven from the host user side
// Assumes: Card contents are static while a command runs
// Notes: Response bytes are collected at the host user output
`timescale 1ns/1ps
module card_apdu_framing_tb;
  logic sys_clk, reset_n, cmd_start, data_in_valid, resp_ready, prepaid, group_held;
  logic [7:0] cmd_ins, cmd_lc, data_in, part, mcount;
  logic [15:0] sysid, card_instr, return_code, status_ok;
  logic [47:0] cid;
  logic [255:0] key;
  logic [63:0] cbc;
  logic [127:0] mcodes;
  logic data_in_ready_r, busy_r, reject_r, resp_valid_r, resp_last_r, done_r, cmd_data_valid_r, cmd_done_r;
  logic [7:0] resp_data_r, cmd_ins_r, cmd_data_r;
  logic [15:0] status_word_r;
  logic [7:0] rq[$], dq[$], eq[$];
  int errors, check_count, done_seen, cdone;
  caf_link_if u_caf_link_if();
  caf_host u_caf_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(u_caf_link_if.receiver_host),
    .cmd_start(cmd_start), .cmd_ins(cmd_ins), .cmd_lc(cmd_lc), .data_in(data_in),
    .data_in_valid(data_in_valid), .data_in_ready_r(data_in_ready_r), .busy_r(busy_r), .reject_r(reject_r),
    .resp_data_r(resp_data_r), .resp_valid_r(resp_valid_r), .resp_last_r(resp_last_r),
    .resp_ready(resp_ready), .status_word_r(status_word_r), .done_r(done_r));
  caf_card u_caf_card (.sys_clk(sys_clk), .reset_n(reset_n), .link(u_caf_link_if.card_end),
    .access_system_identifier(sysid), .card_identity_value(cid), .prepaid(prepaid), .partition_len(part),
    .descramble_key(key), .cbc_init(cbc), .mgmt_count(mcount), .broadcast_management_code(mcodes),
    .group_held(group_held), .card_instr(card_instr), .return_code(return_code), .status_ok(status_ok),
    .cmd_ins_r(cmd_ins_r), .cmd_data_r(cmd_data_r), .cmd_data_valid_r(cmd_data_valid_r),
    .cmd_done_r(cmd_done_r));
  caf_link_chk u_caf_link_chk (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_byte(u_caf_link_if.cmd_byte),
    .cmd_valid(u_caf_link_if.cmd_valid), .cmd_ready(u_caf_link_if.cmd_ready), .cmd_last(u_caf_link_if.cmd_last),
    .rsp_byte(u_caf_link_if.rsp_byte), .rsp_valid(u_caf_link_if.rsp_valid), .rsp_ready(u_caf_link_if.rsp_ready),
    .rsp_last(u_caf_link_if.rsp_last));
  // Clock of 5 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Collect response bytes, card-side data bytes and completions; step data source
  always @(posedge sys_clk) begin
    if (resp_valid_r === 1'b1 && resp_ready === 1'b1) rq.push_back(resp_data_r);
    if (cmd_data_valid_r === 1'b1) dq.push_back(cmd_data_r);
    if (done_r === 1'b1) done_seen++;
    if (cmd_done_r === 1'b1) cdone++;
    if (data_in_valid === 1'b1 && data_in_ready_r === 1'b1) data_in <= data_in + 8'h01;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // Issue one command, optionally stalling the response side, then compare
  task automatic run(input logic [7:0] ins, input logic [7:0] lc, input int stall);
    int n;
    rq.delete();
    dq.delete();
    done_seen = 0;
    cdone = 0;
    @(negedge sys_clk);
    cmd_ins = ins;
    cmd_lc = lc;
    data_in = 8'ha0;
    cmd_start = 1'b1;
    resp_ready = (stall == 0);
    @(negedge sys_clk);
    cmd_start = 1'b0;
    check(busy_r, 16'h0001);
    repeat (stall) @(negedge sys_clk);
    if (stall > 0) check(u_caf_link_if.rsp_valid, 16'h0001);
    resp_ready = 1'b1;
    n = 0;
    while (done_seen == 0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      final_report();
    end
    foreach (eq[i]) check(rq[i], eq[i]);
    check(16'(rq.size()), 16'(eq.size() + 2));
    check(resp_last_r, 16'h0001);
    check(busy_r, 16'h0000);
    check(16'(cdone), 16'h0001);
    check(status_word_r, status_ok);
    check(cmd_ins_r, ins);
  endtask : run
  // Expected initial settings body, multi-byte fields high byte first
  task automatic exp_init(input logic [15:0] instr, input logic [7:0] typ, input int n);
    eq = {8'h00, 8'h37 + 8'(2 * n), instr[15:8], instr[7:0], return_code[15:8], return_code[7:0],
      sysid[15:8], sysid[7:0]};
    for (int i = 5; i >= 0; i--) eq.push_back(cid[8*i +: 8]);
    eq.push_back(typ);
    eq.push_back(part);
    for (int i = 31; i >= 0; i--) eq.push_back(key[8*i +: 8]);
    for (int i = 7; i >= 0; i--) eq.push_back(cbc[8*i +: 8]);
    eq.push_back(8'(n));
    for (int i = 0; i < n; i++) begin
      eq.push_back(mcodes[16*i+8 +: 8]);
      eq.push_back(mcodes[16*i +: 8]);
    end
  endtask : exp_init
  initial begin
    logic [7:0] bad[3];
    bad = '{8'h31, 8'h62, 8'h9c};
    errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    {cmd_start, data_in_valid, resp_ready, cmd_ins, cmd_lc, data_in} = '0;
    {sysid, cid, part, prepaid, group_held} = {16'h1a2b, 48'h3c4d5e6f7081, 8'h55, 1'b1, 1'b0};
    key = {4{64'h0123456789abcdef}};
    cbc = 64'hf0e1d2c3b4a59687;
    mcodes = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    {mcount, card_instr, return_code, status_ok} = {8'h03, 16'h2468, 16'h0a0b, 16'h9000};
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    data_in_valid = 1'b1;
    exp_init(16'h2468, 8'h00, 3);
    run(8'h30, 8'h00, 0);
    $display("test init prepaid done");
    {prepaid, group_held, mcount} = {1'b0, 1'b1, 8'h08};
    exp_init(16'h0001, 8'h01, 8);
    run(8'h30, 8'h00, 40);
    $display("test init stalled done");
    eq = {8'h00, 8'h04, card_instr[15:8], card_instr[7:0], return_code[15:8], return_code[7:0]};
    run(8'h34, 8'h03, 0);
    check(dq.size(), 16'h0003);
    foreach (dq[i]) check(dq[i], 8'ha0 + 8'(i));
    $display("test data command done");
    cmd_lc = 8'h00;
    foreach (bad[i]) begin
      @(negedge sys_clk);
      cmd_ins = bad[i];
      cmd_start = 1'b1;
      @(negedge sys_clk);
      cmd_start = 1'b0;
      check(reject_r, 16'h0001);
      check(u_caf_link_if.cmd_valid, 16'h0000);
    end
    $display("test refused instructions done");
    final_report();
  end
endmodule : card_apdu_framing_tb
